// ---- parallel_port_mode_control_tb_top.sv ----
// Self-checking bench for the parallel port mode control block
`timescale 1ns/1ns
`include "ppmc_consts.svh"
module parallel_port_mode_control_tb_top;
    import ppmc_pkg::*;
    logic       clk_sys;
    logic       sys_rst;
    logic [7:0] hd_tb;
    logic [7:0] hd_drv;
    logic       hd_en;
    wire  [7:0] host_data_lines;
    logic [4:0] rs;
    logic       rw;
    logic       cs_n;
    logic       ack_n;
    logic [7:0] pa;
    logic [7:0] pb;
    logic [7:0] pa_drv;
    logic [7:0] pa_en;
    logic [7:0] pb_drv;
    logic [7:0] pb_en;
    logic       stb_a;
    logic       stb_b;
    logic       aux_a;
    logic       aux_b;
    logic       aux_a_drv;
    logic       aux_a_en;
    logic       aux_b_drv;
    logic       aux_b_en;
    ppmc_mode_e mode;
    int         fails;
    int         checks_done;
    logic [7:0] rd;
    // Data bus level from whichever side drives it
    assign host_data_lines = hd_en ? hd_drv : hd_tb;
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    ppmc_port_ctrl u_ppmc_port_ctrl (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .host_data_lines(host_data_lines), .host_data_lines_drv(hd_drv),
        .host_data_lines_en(hd_en), .register_select_lines(rs),
        .bus_read_not_write(rw), .chip_select_n(cs_n), .xfer_ack_n(ack_n),
        .port_a_lines(pa), .port_a_lines_drv(pa_drv), .port_a_lines_en(pa_en),
        .port_b_lines(pb), .port_b_lines_drv(pb_drv), .port_b_lines_en(pb_en),
        .port_a_strobe_pin(stb_a), .port_a_aux_handshake_pin(aux_a),
        .port_a_aux_handshake_pin_drv(aux_a_drv),
        .port_a_aux_handshake_pin_en(aux_a_en),
        .port_b_strobe_pin(stb_b), .port_b_aux_handshake_pin(aux_b),
        .port_b_aux_handshake_pin_drv(aux_b_drv),
        .port_b_aux_handshake_pin_en(aux_b_en), .port_mode(mode));
    ppmc_periph_model u_ppmc_periph_model (
        .clk_sys(clk_sys), .a_drv(pa_drv), .a_en(pa_en), .b_drv(pb_drv),
        .b_en(pb_en), .aux_a_drv(aux_a_drv), .aux_a_en(aux_a_en),
        .aux_b_drv(aux_b_drv), .aux_b_en(aux_b_en), .port_a_lines(pa),
        .port_b_lines(pb), .port_a_strobe_pin(stb_a),
        .port_b_strobe_pin(stb_b), .port_a_aux_handshake_pin(aux_a),
        .port_b_aux_handshake_pin(aux_b));
    // Closing report shared by the main sequence and every timeout
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                        input string msg);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask
    task automatic chk_mode(input ppmc_mode_e got, input ppmc_mode_e exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: port mode %0d", $time, got);
        end
    endtask
    // One bus cycle held until the acknowledge, then released
    task automatic bus(input logic [4:0] a, input logic w,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk_sys);
        cs_n <= 1'b0;
        rw <= ~w;
        rs <= a;
        hd_tb <= w ? d : ~hd_tb;
        // Look just after each edge, once the outputs have settled
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            #1;
            if (ack_n === 1'b0) break;
        end
        if (n == 20) begin
            fails++;
            end_sim();
        end
        q = host_data_lines;
        @(posedge clk_sys);
        cs_n <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            #1;
            if (ack_n === 1'b1) break;
        end
        if (n == 20) begin
            fails++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, rd);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] e,
                       input string msg);
        bus(a, 1'b0, 8'h00, rd);
        chk8(rd, e, msg);
    endtask
    // Reset state and mode field decoding with read back
    task automatic t_modes();
        chk8({7'h00, ack_n}, 8'h01, "ack idle");
        chk8(pa_en | pb_en, 8'h00, "ports not driven");
        rdc(`PPMC_OFS_GCTL, 8'h00, "global reset");
        for (int m = 3; m >= 0; m--) begin
            wr(`PPMC_OFS_GCTL, {m[1:0], 6'h0f});
            chk_mode(mode, ppmc_mode_e'(m[1:0]));
            rdc(`PPMC_OFS_GCTL, {m[1:0], 6'h0f}, "global read");
        end
    endtask
    // Plain output in submode 1X and an unmapped select
    task automatic t_plain();
        wr(`PPMC_OFS_CTL_A, 8'h80);
        wr(`PPMC_OFS_DDR_A, 8'hf0);
        wr(`PPMC_OFS_DATA_A, 8'h5a);
        chk8(pa_en, 8'hf0, "ddr a");
        chk8(pa_drv & pa_en, 8'h50, "data a out");
        wr(5'h1f, 8'hff);
        rdc(5'h1f, 8'h00, "unmapped");
        wr(`PPMC_OFS_DDR_A, 8'h00);
    endtask
    // Latched input, interlocked room handshake and buffer full refusal
    task automatic t_latch();
        wr(`PPMC_OFS_CTL_A, 8'h20);
        chk8({6'h0, aux_a_en, aux_a_drv}, 8'h03, "room shown");
        u_ppmc_periph_model.a_val = 8'h11;
        u_ppmc_periph_model.pulse(1'b0);
        rdc(`PPMC_OFS_STAT, {3'h0, 1'b1, 4'ha}, "valid a");
        u_ppmc_periph_model.a_val = 8'h22;
        u_ppmc_periph_model.pulse(1'b0);
        chk8({7'h0, aux_a_drv}, 8'h00, "full shown");
        u_ppmc_periph_model.a_val = 8'h33;
        u_ppmc_periph_model.pulse(1'b0);
        rdc(`PPMC_OFS_DATA_A, 8'h11, "first word");
        rdc(`PPMC_OFS_DATA_A, 8'h22, "second word");
        rdc(`PPMC_OFS_STAT, 8'h0a, "drained");
    endtask
    // Port B mirrors port A: general output on its auxiliary pin
    task automatic t_gpo();
        wr(`PPMC_OFS_CTL_B, 8'h14);
        chk8({6'h0, aux_b_en, aux_b_drv}, 8'h03, "aux b high");
        wr(`PPMC_OFS_CTL_B, 8'h10);
        chk8({6'h0, aux_b_en, aux_b_drv}, 8'h02, "aux b low");
        wr(`PPMC_OFS_CTL_B, 8'h00);
        wr(`PPMC_OFS_CTL_A, 8'h00);
        u_ppmc_periph_model.aux_a_val = 1'b0;
        u_ppmc_periph_model.aux_b_val = 1'b0;
        rdc(`PPMC_OFS_STAT, 8'h00, "pin levels");
    endtask
    // Sixteen bit input: both bytes latched by the port B strobe
    task automatic t_uni16();
        wr(`PPMC_OFS_GCTL, 8'h4f);
        u_ppmc_periph_model.a_val = 8'h12;
        u_ppmc_periph_model.b_val = 8'h34;
        u_ppmc_periph_model.pulse(1'b1);
        u_ppmc_periph_model.a_val = 8'h00;
        rdc(`PPMC_OFS_DATA_A, 8'h12, "high byte");
        rdc(`PPMC_OFS_DATA_B, 8'h34, "low byte");
    endtask
    // Bidirectional: port A strobe turns port B drivers on
    task automatic t_bid8();
        wr(`PPMC_OFS_GCTL, 8'h8f);
        wr(`PPMC_OFS_DDR_B, 8'hff);
        chk8(pb_en, 8'h00, "ddr ignored");
        u_ppmc_periph_model.b_val = 8'h6c;
        u_ppmc_periph_model.pulse(1'b1);
        rdc(`PPMC_OFS_DATA_B, 8'h6c, "bidir in");
        @(posedge clk_sys);
        u_ppmc_periph_model.port_a_strobe_pin <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk8(pb_en, 8'hff, "drivers on");
        u_ppmc_periph_model.port_a_strobe_pin <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk8(pb_en, 8'h00, "drivers off");
        wr(`PPMC_OFS_DATA_B, 8'h3c);
        chk8(pb_drv, 8'h3c, "bidir out");
    endtask
    // Main sequence
    initial begin
        fails = 0;
        checks_done = 0;
        sys_rst = 1'b1;
        hd_tb = 8'h00;
        rs = 5'h00;
        rw = 1'b1;
        cs_n = 1'b1;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        t_modes();
        t_plain();
        t_latch();
        t_gpo();
        t_uni16();
        t_bid8();
        end_sim();
    end
endmodule

// ---- ppmc_consts.svh ----
// Offsets, field positions, reset values and timing counts for port control
`ifndef PPMC_CONSTS_SVH
`define PPMC_CONSTS_SVH

`define PPMC_OFS_GCTL   5'h00
`define PPMC_OFS_CTL_A  5'h06
`define PPMC_OFS_CTL_B  5'h07
`define PPMC_OFS_DDR_A  5'h02
`define PPMC_OFS_DDR_B  5'h03
`define PPMC_OFS_DATA_A 5'h08
`define PPMC_OFS_DATA_B 5'h09
`define PPMC_OFS_STAT   5'h0d

`define PPMC_MODE_HI    7
`define PPMC_MODE_LO    6
`define PPMC_SUB_HI     7
`define PPMC_SUB_LO     6
`define PPMC_FUNC_HI    5
`define PPMC_FUNC_LO    4
`define PPMC_PULSED_BIT 3
`define PPMC_GPO_BIT    2

`define PPMC_RST_REG    8'h00

`define PPMC_CLK_NS     8
`define PPMC_PULSE_NS   32
`define PPMC_PULSE_CYC  ((`PPMC_PULSE_NS + `PPMC_CLK_NS - 1) / `PPMC_CLK_NS)

`endif

// ---- ppmc_pair_buf.sv ----
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ns
module ppmc_pair_buf #(
    parameter int W = 8
) (
    input wire logic   clk_sys,
    input wire logic   sys_rst,
    ppmc_stream_if.rx  fill,
    ppmc_stream_if.tx  drain
);
    import ppmc_pkg::*;

    logic [W-1:0] mem_q [2];
    logic         wptr_q;
    logic         rptr_q;
    logic [1:0]   cnt_q;
    logic         do_push;
    logic         do_pop;

    // Honest full and empty flags
    assign fill.ready  = (cnt_q != 2'h2);
    assign drain.valid = (cnt_q != 2'h0);
    assign drain.data  = mem_q[rptr_q];
    assign do_push     = fill.valid & fill.ready;
    assign do_pop      = drain.valid & drain.ready;

    // Storage written at the write pointer
    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem_q[wptr_q] <= fill.data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wptr_q <= 1'b0;
            rptr_q <= 1'b0;
            cnt_q  <= 2'h0;
        end else begin
            if (do_push) wptr_q <= ~wptr_q;
            if (do_pop) rptr_q <= ~rptr_q;
            cnt_q <= cnt_q + {1'b0, do_push} - {1'b0, do_pop};
        end
    end
endmodule

// ---- ppmc_periph_model.sv ----
// Parallel peripheral model: port pins, strobes and auxiliary handshakes
`timescale 1ns/1ns
module ppmc_periph_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] a_drv,
    input  wire logic [7:0] a_en,
    input  wire logic [7:0] b_drv,
    input  wire logic [7:0] b_en,
    input  wire logic       aux_a_drv,
    input  wire logic       aux_a_en,
    input  wire logic       aux_b_drv,
    input  wire logic       aux_b_en,
    output logic [7:0]      port_a_lines,
    output logic [7:0]      port_b_lines,
    output logic            port_a_strobe_pin,
    output logic            port_b_strobe_pin,
    output logic            port_a_aux_handshake_pin,
    output logic            port_b_aux_handshake_pin
);
    logic [7:0] a_val;
    logic [7:0] b_val;
    logic       aux_a_val;
    logic       aux_b_val;
    // Idle levels; auxiliary pins rest high like their pull-ups
    initial begin
        a_val = 8'h00;
        b_val = 8'h00;
        aux_a_val = 1'b1;
        aux_b_val = 1'b1;
        port_a_strobe_pin = 1'b0;
        port_b_strobe_pin = 1'b0;
    end
    // Each bit shows the device where it drives, the peripheral elsewhere
    assign port_a_lines = (a_en & a_drv) | (~a_en & a_val);
    assign port_b_lines = (b_en & b_drv) | (~b_en & b_val);
    assign port_a_aux_handshake_pin = aux_a_en ? aux_a_drv : aux_a_val;
    assign port_b_aux_handshake_pin = aux_b_en ? aux_b_drv : aux_b_val;
    // Strobe asserted three cycles, then a quiet gap for the synchroniser
    task automatic pulse(input bit sel_b);
        @(posedge clk_sys);
        if (sel_b) port_b_strobe_pin <= 1'b1;
        else port_a_strobe_pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        port_a_strobe_pin <= 1'b0;
        port_b_strobe_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule

// ---- ppmc_pkg.sv ----
// Types shared by the port mode control block
package ppmc_pkg;
    typedef enum logic [1:0] {
        PPMC_UNI8,
        PPMC_UNI16,
        PPMC_BID8,
        PPMC_BID16
    } ppmc_mode_e;

    typedef enum logic {
        PPMC_BUS_IDLE,
        PPMC_BUS_ACK
    } ppmc_bus_e;
endpackage

// ---- ppmc_port_ctrl.sv ----
// Dual parallel port mode, submode and handshake pin control
`timescale 1ns/1ns
`include "ppmc_consts.svh"
module ppmc_port_ctrl #(
    parameter int PULSE_CYC = `PPMC_PULSE_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic [7:0] host_data_lines,
    output logic [7:0]      host_data_lines_drv,
    output logic            host_data_lines_en,
    input  wire logic [4:0] register_select_lines,
    input  wire logic       bus_read_not_write,
    input  wire logic       chip_select_n,
    output logic            xfer_ack_n,
    input  wire logic [7:0] port_a_lines,
    output logic [7:0]      port_a_lines_drv,
    output logic [7:0]      port_a_lines_en,
    input  wire logic [7:0] port_b_lines,
    output logic [7:0]      port_b_lines_drv,
    output logic [7:0]      port_b_lines_en,
    input  wire logic       port_a_strobe_pin,
    input  wire logic       port_a_aux_handshake_pin,
    output logic            port_a_aux_handshake_pin_drv,
    output logic            port_a_aux_handshake_pin_en,
    input  wire logic       port_b_strobe_pin,
    input  wire logic       port_b_aux_handshake_pin,
    output logic            port_b_aux_handshake_pin_drv,
    output logic            port_b_aux_handshake_pin_en,
    output ppmc_pkg::ppmc_mode_e port_mode
);
    import ppmc_pkg::*;

    localparam int SW = 35;
    localparam logic [3:0] PW = 4'(PULSE_CYC);

    logic [SW-1:0]   s1_q;
    logic [SW-1:0]   s2_q;
    logic [7:0]      d_s;
    logic [4:0]      rs_s;
    logic            rw_s;
    logic            cs_n_s;
    logic [1:0][7:0] pl_s;
    logic [3:0]      hs_s;
    logic [3:0]      hs_act;
    logic [3:0]      hs_prev_q;
    logic [3:0]      hs_edge;
    ppmc_bus_e       bus_q;
    logic            rd_hold_q;
    logic            acc;
    logic            wr;
    logic            rd;
    logic [7:0]      gctl_q;
    logic [1:0][7:0] ctl_q;
    logic [1:0][7:0] ddr_q;
    logic [7:0]      rdata_q;
    logic [7:0]      rmux;
    logic            wide;
    logic            bidir;
    logic [1:0]      in_role;
    logic [1:0]      out_role;
    logic [1:0]      bid_port;
    logic [1:0]      latch_ev;
    logic [1:0]      ack_ev;
    logic [1:0]      wr_data;
    logic [1:0]      pop;
    logic [1:0]      fv;
    logic [1:0]      frdy;
    logic [1:0][7:0] fd;
    logic [1:0][7:0] pin_q_w;
    logic [1:0]      pin_v_w;
    logic [1:0]      load_w;
    logic [1:0]      aux_act;
    logic [1:0]      aux_en;
    logic [1:0]      pulse_act;

    // Two-stage synchroniser on every pin input
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // Handshake stages rest low, matching the edge detector
            s1_q <= {{(SW-4){1'b1}}, 4'h0};
            s2_q <= {{(SW-4){1'b1}}, 4'h0};
        end else begin
            s1_q <= {host_data_lines, register_select_lines,
                     bus_read_not_write, chip_select_n,
                     port_a_lines, port_b_lines,
                     port_b_aux_handshake_pin, port_b_strobe_pin,
                     port_a_aux_handshake_pin, port_a_strobe_pin};
            s2_q <= s1_q;
        end
    end
    assign {d_s, rs_s, rw_s, cs_n_s, pl_s[0], pl_s[1], hs_s} = s2_q;

    // Pin sense: asserted when level matches its sense bit
    assign hs_act  = hs_s ~^ gctl_q[3:0];
    // Only a pin transition counts, never a sense change or reset
    assign hs_edge = hs_act & (hs_s ^ hs_prev_q);

    // Previous pin level for edge detection
    always_ff @(posedge clk_sys) begin
        if (sys_rst) hs_prev_q <= 4'h0;
        else hs_prev_q <= hs_s;
    end

    // Host bus cycle: take access, hold acknowledge until deselect
    assign acc = (bus_q == PPMC_BUS_IDLE) & ~cs_n_s;
    assign wr  = acc & ~rw_s;
    assign rd  = acc & rw_s;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bus_q <= PPMC_BUS_IDLE;
        end else begin
            case (bus_q)
                PPMC_BUS_IDLE: if (acc) bus_q <= PPMC_BUS_ACK;
                PPMC_BUS_ACK:  if (cs_n_s) bus_q <= PPMC_BUS_IDLE;
                default:       bus_q <= PPMC_BUS_IDLE;
            endcase
        end
    end

    // Read direction remembered for the data bus drivers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) rd_hold_q <= 1'b0;
        else if (acc) rd_hold_q <= rw_s;
    end
    assign xfer_ack_n          = (bus_q != PPMC_BUS_ACK);
    assign host_data_lines_en  = (bus_q == PPMC_BUS_ACK) & rd_hold_q;
    assign host_data_lines_drv = rdata_q;

    // Control register writes decoded from the select lines
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            gctl_q <= `PPMC_RST_REG;
            ctl_q  <= {`PPMC_RST_REG, `PPMC_RST_REG};
            ddr_q  <= {`PPMC_RST_REG, `PPMC_RST_REG};
        end else if (wr) begin
            case (rs_s)
                `PPMC_OFS_GCTL:  gctl_q   <= d_s;
                `PPMC_OFS_CTL_A: ctl_q[0] <= d_s;
                `PPMC_OFS_CTL_B: ctl_q[1] <= d_s;
                `PPMC_OFS_DDR_A: ddr_q[0] <= d_s;
                `PPMC_OFS_DDR_B: ddr_q[1] <= d_s;
                default: ;
            endcase
        end
    end
    assign wr_data[0] = wr & (rs_s == `PPMC_OFS_DATA_A);
    assign wr_data[1] = wr & (rs_s == `PPMC_OFS_DATA_B);

    // Mode decode
    assign port_mode = ppmc_mode_e'(gctl_q[`PPMC_MODE_HI:`PPMC_MODE_LO]);
    assign wide  = (port_mode == PPMC_UNI16) | (port_mode == PPMC_BID16);
    assign bidir = (port_mode == PPMC_BID8) | (port_mode == PPMC_BID16);
    assign bid_port[0] = (port_mode == PPMC_BID16);
    assign bid_port[1] = bidir;

    // Port roles from mode and submode
    always_comb begin
        in_role  = 2'b00;
        out_role = 2'b00;
        latch_ev = 2'b00;
        ack_ev   = 2'b00;
        case (port_mode)
            PPMC_UNI8: begin
                for (int i = 0; i < 2; i++) begin
                    in_role[i]  = (ctl_q[i][7:6] == 2'b00);
                    out_role[i] = (ctl_q[i][7:6] == 2'b01);
                    latch_ev[i] = hs_edge[2*i] & in_role[i];
                    ack_ev[i]   = hs_edge[2*i] & out_role[i];
                end
            end
            PPMC_UNI16: begin
                // Port A submode ignored; it follows port B
                in_role  = {2{~ctl_q[1][`PPMC_SUB_LO]}};
                out_role = {2{ctl_q[1][`PPMC_SUB_LO]}};
                latch_ev = {2{hs_edge[2]}} & in_role;
                ack_ev   = {2{hs_edge[2]}} & out_role;
            end
            default: begin
                // Submodes ignored in both bidirectional modes
                in_role  = bid_port;
                out_role = bid_port;
                latch_ev = {2{hs_edge[2]}} & bid_port;
                ack_ev   = {2{hs_edge[0]}} & bid_port;
            end
        endcase
    end

    // Reading a latched data register drains the buffer
    assign pop[0] = rd & in_role[0] & ((rs_s == `PPMC_OFS_DATA_A) & ~wide
                    | (rs_s == `PPMC_OFS_DATA_B) & wide);
    assign pop[1] = rd & in_role[1] & (rs_s == `PPMC_OFS_DATA_B);

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_port
            ppmc_stream_if #(.W(8)) fill_if ();
            ppmc_stream_if #(.W(8)) drain_if ();
            logic [7:0] pend_q;
            logic       pend_v_q;
            logic [7:0] pin_q;
            logic       pin_v_q;
            logic       load;

            // Double-buffered input: strobe latches the pins
            assign fill_if.valid  = latch_ev[g];
            assign fill_if.data   = pl_s[g];
            assign drain_if.ready = pop[g];
            assign fv[g]   = drain_if.valid;
            assign fd[g]   = drain_if.data;
            assign frdy[g] = fill_if.ready;

            ppmc_pair_buf #(.W(8)) u_buf (
                .clk_sys (clk_sys),
                .sys_rst (sys_rst),
                .fill    (fill_if),
                .drain   (drain_if)
            );

            // Output path: pending word moves out when the pins are free
            assign load = out_role[g] & pend_v_q & (~pin_v_q | ack_ev[g]);
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    pend_q   <= 8'h00;
                    pend_v_q <= 1'b0;
                    pin_q    <= 8'h00;
                    pin_v_q  <= 1'b0;
                end else if (!out_role[g]) begin
                    // Single-buffered output writes the pins directly
                    pend_v_q <= 1'b0;
                    pin_v_q  <= 1'b0;
                    if (wr_data[g]) pin_q <= d_s;
                end else begin
                    if (wr_data[g]) pend_q <= d_s;
                    if (wr_data[g]) pend_v_q <= 1'b1;
                    else if (load) pend_v_q <= 1'b0;
                    if (load) begin
                        pin_q   <= pend_q;
                        pin_v_q <= 1'b1;
                    end else if (ack_ev[g]) begin
                        pin_v_q <= 1'b0;
                    end
                end
            end
            assign pin_q_w[g] = pin_q;
            assign pin_v_w[g] = pin_v_q;
            assign load_w[g]  = load;
        end
    endgenerate

    // Port pin drivers: bidirectional ports follow the port A strobe
    assign port_a_lines_drv = pin_q_w[0];
    assign port_b_lines_drv = pin_q_w[1];
    assign port_a_lines_en  = bid_port[0] ? {8{hs_act[0]}} : ddr_q[0];
    assign port_b_lines_en  = bid_port[1] ? {8{hs_act[0]}} : ddr_q[1];

    // Auxiliary handshake pins
    generate
        for (g = 0; g < 2; g++) begin : g_aux
            logic [3:0] pcnt_q;
            logic       hs_ok;
            logic       is_out;
            logic       own;
            logic       lvl;
            logic       trig;
            logic [1:0] fn;

            // Handshake allowed only where the mode gives the pin a partner
            assign own = (port_mode == PPMC_UNI8) ? 1'(g) : 1'b1;
            assign hs_ok = bidir | (port_mode == PPMC_UNI8)
                           & ~ctl_q[g][`PPMC_SUB_HI]
                           | (port_mode == PPMC_UNI16) & (g == 1);
            assign is_out = bidir ? (g == 0) : out_role[own];
            assign fn = ctl_q[g][`PPMC_FUNC_HI:`PPMC_FUNC_LO];
            assign lvl = is_out ? pin_v_w[own] : frdy[own];
            assign trig = is_out ? load_w[own] : latch_ev[own];

            // Pulsed protocol: fixed pulse after each transfer
            always_ff @(posedge clk_sys) begin
                if (sys_rst) pcnt_q <= 4'h0;
                else if (trig) pcnt_q <= PW;
                else if (pcnt_q != 4'h0) pcnt_q <= pcnt_q - 4'h1;
            end
            assign pulse_act[g] = (pcnt_q != 4'h0);

            always_comb begin
                aux_act[g] = ctl_q[g][`PPMC_GPO_BIT];
                aux_en[g]  = 1'b0;
                if (hs_ok & (bidir | fn[1])) begin
                    aux_en[g] = 1'b1;
                    // Interlocked unless the pulsed bit is set
                    aux_act[g] = ctl_q[g][`PPMC_PULSED_BIT] ? pulse_act[g]
                                 : lvl;
                end else if (fn == 2'b01) begin
                    aux_en[g] = 1'b1;
                end
            end
        end
    endgenerate
    assign port_a_aux_handshake_pin_drv = aux_act[0] ~^ gctl_q[1];
    assign port_b_aux_handshake_pin_drv = aux_act[1] ~^ gctl_q[3];
    assign port_a_aux_handshake_pin_en  = aux_en[0];
    assign port_b_aux_handshake_pin_en  = aux_en[1];

    // Register read multiplexer
    always_comb begin
        rmux = 8'h00;
        case (rs_s)
            `PPMC_OFS_GCTL:  rmux = gctl_q;
            `PPMC_OFS_CTL_A: rmux = ctl_q[0];
            `PPMC_OFS_CTL_B: rmux = ctl_q[1];
            `PPMC_OFS_DDR_A: rmux = ddr_q[0];
            `PPMC_OFS_DDR_B: rmux = ddr_q[1];
            `PPMC_OFS_DATA_A: rmux = (in_role[0] & fv[0]) ? fd[0]
                              : (ddr_q[0] & pin_q_w[0] | ~ddr_q[0] & pl_s[0]);
            `PPMC_OFS_DATA_B: rmux = (in_role[1] & fv[1]) ? fd[1]
                              : (ddr_q[1] & pin_q_w[1] | ~ddr_q[1] & pl_s[1]);
            `PPMC_OFS_STAT:  rmux = {pin_v_w, fv, hs_s};
            default: rmux = 8'h00;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) rdata_q <= 8'h00;
        else if (rd) rdata_q <= rmux;
    end

    logic pend_v_w0;
    logic trig_a;
    assign pend_v_w0 = g_port[0].pend_v_q;
    assign trig_a    = g_aux[0].trig;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    chk_mode_write: assert property (wr && rs_s == `PPMC_OFS_GCTL |=> port_mode == ppmc_mode_e'($past(d_s[7:6])))
        else $error("mode not taken from write");
    chk_sub_write: assert property (wr && rs_s == `PPMC_OFS_CTL_B |=> ctl_q[1][7:6] == $past(d_s[7:6]))
        else $error("submode not taken from write");
    chk_latch_push: assert property (port_mode == PPMC_UNI8 && ctl_q[0][7:6] == 2'b00 && hs_edge[0] && frdy[0] && !pop[0] |=> fv[0])
        else $error("strobe did not latch port A");
    chk_ack_frees: assert property (out_role[0] && ack_ev[0] && !pend_v_w0 |=> !pin_v_w[0])
        else $error("acknowledge did not free output");
    chk_bidir_drive: assert property (bidir && hs_act[0] |-> port_b_lines_en == 8'hff)
        else $error("bidirectional drivers off");
    chk_bus_ack: assert property (rd |=> !xfer_ack_n && host_data_lines_en)
        else $error("read not acknowledged");
    chk_write_quiet: assert property (wr |=> !xfer_ack_n && !host_data_lines_en)
        else $error("write drove data bus");
    chk_stat_level: assert property (rd && rs_s == `PPMC_OFS_STAT |=> host_data_lines_drv[3:0] == $past(hs_s))
        else $error("status shows wrong pin level");
    chk_pulse_width: assert property ($rose(pulse_act[0]) && !trig_a ##1 !trig_a[*3] |-> pulse_act[0] ##1 !pulse_act[0])
        else $error("pulse width wrong");
endmodule

// ---- ppmc_stream_if.sv ----
// Valid/ready word carrier between the control core and its buffers
`timescale 1ns/1ns
interface ppmc_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport tx (output valid, output data, input ready);
    modport rx (input valid, input data, output ready);
endinterface
